// ==== tb/fsw_top_chk.sv ====
`timescale 1ns/1ps
module fsw_top_chk #(
    parameter int PROG_CYC  = 8,  // timed program length
    parameter int ERASE_CYC = 8   // timed erase length
) (
    // clock and reset
    input wire logic        i_sys_clk,
    input wire logic        i_rstn,
    // apb side
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // array and cpu side
    input wire logic [11:0] o_flash_block,
    input wire logic        o_flash_prog,
    input wire logic        o_flash_erase,
    input wire logic        o_cpu_stall,
    input wire logic        o_irq
);
    logic [15:0] run_q;  // stall cycles seen so far
    logic        ers_q;  // last stall cycle was an erase
    // anything past the last word or off alignment is unmapped
    wire bad_addr = (i_paddr[1:0] != 2'b00) || (i_paddr > fsw_pkg::ADDR_STATUS);
    // start request taken at this edge
    wire ctrl_start = i_psel && i_penable && i_pwrite && (i_paddr == fsw_pkg::ADDR_CTRL)
                      && i_pwdata[fsw_pkg::CTRL_WR_BIT];
    // stall length counter, cleared whenever the cpu runs
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            run_q <= 16'h0000;
            ers_q <= 1'b0;
        end else begin
            run_q <= o_cpu_stall ? run_q + 16'h0001 : 16'h0000;
            ers_q <= o_flash_erase;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    chk_pready_high: assert property (o_pready)
        else $error("pready low");
    chk_slverr_decode: assert property (o_pslverr == (i_psel && i_penable && bad_addr))
        else $error("slave error decode wrong");
    chk_stall_mirror: assert property (o_cpu_stall == (o_flash_prog || o_flash_erase))
        else $error("stall not tied to timed cycle");
    chk_prog_erase_excl: assert property (!(o_flash_prog && o_flash_erase))
        else $error("program and erase together");
    chk_stall_length: assert property ($fell(o_cpu_stall) |->
        run_q == (ers_q ? ERASE_CYC : PROG_CYC)) else $error("stall length wrong");
    chk_stall_bound: assert property (o_cpu_stall |->
        run_q < (o_flash_erase ? ERASE_CYC : PROG_CYC)) else $error("stall too long");
    chk_block_hold: assert property (o_cpu_stall && $past(o_cpu_stall) |->
        $stable(o_flash_block)) else $error("block moved in cycle");
    chk_start_cause: assert property ($rose(o_cpu_stall) |-> $past(ctrl_start))
        else $error("cycle began without start write");
    chk_quiet_reset: assert property ($rose(i_rstn) |-> !o_cpu_stall [*3])
        else $error("cycle resumed after reset");
    cover property ($rose(o_flash_prog));
    cover property ($rose(o_flash_erase));
    cover property (o_pslverr);
    cover property ($rose(o_irq));
endmodule

// ==== tb/test_flash_self_program_writer.sv ====
`timescale 1ns/1ps
module test_flash_self_program_writer;
    localparam int P_CYC = 24;  // shortened program time
    localparam int E_CYC = 40;  // shortened erase time
    logic        clk    = 1'b0;   // system clock
    logic        rstn   = 1'b0;   // system reset, active low
    logic        por_n  = 1'b0;   // power-on reset, active low
    logic        psel   = 1'b0;   // apb select
    logic        pen    = 1'b0;   // apb enable
    logic        pwr    = 1'b0;   // apb direction
    logic [7:0]  paddr  = 8'h00;  // apb address
    logic [31:0] pwdata = 32'h0;  // apb write data
    logic [5:0]  hidx   = 6'h00;  // holding byte probe
    logic [31:0] prdata;
    logic        pready, pslverr, stall, fprog, ferase, irq;
    logic [7:0]  hbyte;
    logic [11:0] fblk;
    logic [31:0] rd_q;            // last read data
    logic [7:0]  hold_m [64];     // holding register model
    logic [21:0] ptr_m;           // table pointer model
    int          miscompares = 0;
    int          samples_checked = 0;
    int          run_n = 0;       // stall cycles counted
    int          seed = 24;
    always #2 clk = ~clk;
    // count stalled edges for the length check
    always @(posedge clk) if (stall === 1'b1) run_n <= run_n + 1;
    fsw_top #(.PROG_CYC(P_CYC), .ERASE_CYC(E_CYC)) fsw_top_inst (
        .i_sys_clk(clk), .i_rstn(rstn), .i_por_n(por_n), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_hold_idx(hidx),
        .o_hold_byte(hbyte), .o_flash_block(fblk), .o_flash_prog(fprog),
        .o_flash_erase(ferase), .o_cpu_stall(stall), .o_irq(irq));
    task automatic final_report();
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic e = 1'b0);
        int n;
        @(posedge clk);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin miscompares++; final_report(); end
        rd_q = prdata;
        check(pslverr, e, "slave error");
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // unlock then request start; c sets enable and erase select
    task automatic arm(input logic [7:0] k2, input logic [31:0] c);
        apb(1'b1, fsw_pkg::ADDR_CTRL, c);
        apb(1'b1, fsw_pkg::ADDR_KEY, 32'h55);
        apb(1'b1, fsw_pkg::ADDR_KEY, {24'h0, k2});
        run_n <= 0;
        apb(1'b1, fsw_pkg::ADDR_CTRL, c | 32'h2);
    endtask
    task automatic go(input logic [7:0] k2, input logic w, input logic e, input logic x);
        logic [31:0] c;
        int          n;
        c = {27'h0, e, 1'b0, w, 2'b00};
        arm(k2, c);
        @(posedge clk);
        check(stall, x, "stall at start");
        if (x) check(fblk, ptr_m[21:10], "block");
        if (x) check({fprog, ferase}, {!e, e}, "cycle kind");
        apb(1'b0, fsw_pkg::ADDR_CTRL, 32'h0);
        check(rd_q, c | {x, 1'b0}, "ctrl in cycle");
        // software tries to drop the start bit mid cycle
        apb(1'b1, fsw_pkg::ADDR_CTRL, c);
        apb(1'b0, fsw_pkg::ADDR_CTRL, 32'h0);
        check(rd_q, c | {x, 1'b0}, "ctrl after clear try");
        n = 0;
        while (stall !== 1'b0 && n < 200) begin @(posedge clk); n++; end
        if (n >= 200) begin miscompares++; final_report(); end
        if (x) check(run_n, e ? E_CYC : P_CYC, "stall length");
        repeat (3) @(posedge clk);
        check(irq, x, "irq raised");
        apb(1'b0, fsw_pkg::ADDR_IRQ_STAT, 32'h0);
        check(rd_q, x, "done event");
        @(posedge clk);
        check(irq, 1'b0, "irq cleared by read");
        apb(1'b0, fsw_pkg::ADDR_CTRL, 32'h0);
        check(rd_q, c, "ctrl after end");
        // software drops write enable once the cycle is over
        apb(1'b1, fsw_pkg::ADDR_CTRL, 32'h0);
        apb(1'b0, fsw_pkg::ADDR_CTRL, 32'h0);
        check(rd_q, 32'h0, "enable dropped");
    endtask
    // every holding byte against the model
    task automatic hold_chk();
        for (int i = 0; i < 64; i++) begin
            @(posedge clk);
            hidx <= i[5:0];
            repeat (2) @(posedge clk);
            check(hbyte, hold_m[i], "holding byte");
        end
    endtask
    // load 64 holding bytes through pre-incrementing table writes
    task automatic fill();
        logic [7:0] v;
        for (int i = 0; i < 64; i++) begin
            v = 8'($random(seed));
            apb(1'b1, fsw_pkg::ADDR_TBLLAT, {24'h0, v});
            apb(1'b1, fsw_pkg::ADDR_TBLWR, 32'h0);
            ptr_m = ptr_m + 22'h000001;
            hold_m[ptr_m[5:0]] = v;
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, fsw_pkg::ADDR_CTRL, 32'h0);
        check(rd_q, 32'h0, "ctrl reset");
        apb(1'b0, fsw_pkg::ADDR_STATUS, 32'h0);
        check(rd_q, 32'h0, "status reset");
        apb(1'b0, 8'h24, 32'h0, 1'b1);
        check(rd_q, 32'h0, "unmapped read");
        apb(1'b1, fsw_pkg::ADDR_IRQ_MASK, 32'h3);
        // pointer one below a 1024-byte block base
        ptr_m = 22'($random(seed));
        ptr_m[21] = 1'b0;
        ptr_m[9:0] = 10'h3FF;
        apb(1'b1, fsw_pkg::ADDR_TABLE_POINTER, {10'h0, ptr_m});
        fill();
        apb(1'b0, fsw_pkg::ADDR_TABLE_POINTER, 32'h0);
        check(rd_q, {10'h0, ptr_m}, "pointer after fill");
        hold_chk();
        // refused starts, then erase the block before the first program round
        for (int i = 0; i < 4; i++) go((i == 1) ? 8'h12 : 8'hAA, i != 0, i == 2, i >= 2);
        // fifteen more rounds of 64 bytes fill the erased block
        for (int r = 1; r < 16; r++) begin
            fill();
            go(8'hAA, 1'b1, 1'b0, 1'b1);
        end
        hold_chk();
        // reset in mid cycle must leave the error flag behind
        arm(8'hAA, 32'h4);
        repeat (5) @(posedge clk);
        check(stall, 1'b1, "abort cycle running");
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        check(stall, 1'b0, "no stall after reset");
        apb(1'b0, fsw_pkg::ADDR_CTRL, 32'h0);
        check(rd_q & 32'h8, 32'h8, "error flag");
        apb(1'b0, fsw_pkg::ADDR_IRQ_STAT, 32'h0);
        check(rd_q & 32'h2, 32'h2, "abort event");
        // system reset dropped mask and pointer; software rewrites the round
        apb(1'b1, fsw_pkg::ADDR_IRQ_MASK, 32'h3);
        apb(1'b1, fsw_pkg::ADDR_TABLE_POINTER, {10'h0, ptr_m});
        go(8'hAA, 1'b1, 1'b0, 1'b1);
        final_report();
    end
endmodule
bind fsw_top fsw_top_chk #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) fsw_top_chk_inst (.*);

// ==== verilog/fsw_pkg.sv ====
package fsw_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] ADDR_CTRL     = 8'h00; // flash_control_reg
    localparam logic [7:0] ADDR_KEY      = 8'h04; // unlock_key_reg, write only
    localparam logic [7:0] ADDR_TABLE_POINTER   = 8'h08; // table_pointer
    localparam logic [7:0] ADDR_TBLLAT   = 8'h0C; // table_latch
    localparam logic [7:0] ADDR_TBLWR    = 8'h10; // table_write command strobe
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14; // sticky events, read clears
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18; // interrupt mask
    localparam logic [7:0] ADDR_STATUS   = 8'h1C; // live sequencer state

    // flash_control_reg bit positions
    localparam int CTRL_WR_BIT    = 1;  // write start
    localparam int CTRL_FLASH_WRITE_ENABLE_BIT  = 2;  // flash_write_enable
    localparam int CTRL_WRITE_ERROR_FLAG_BIT = 3;  // write_error_flag
    localparam int CTRL_ERASE_BIT = 4;  // erase select

    // interrupt status bit positions
    localparam int IRQ_DONE_BIT = 0;  // cycle finished
    localparam int IRQ_ERR_BIT  = 1;  // aborted cycle detected
    localparam int IRQ_W        = 2;

    // unlock key values
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // table pointer geometry
    localparam int PTR_W       = 22; // full pointer width
    localparam int HOLD_IDX_W  = 7;  // unused; hold_sel picks a holding register from 6 low bits
    localparam int HOLD_DEPTH  = 64; // holding registers per round
    localparam int BLOCK_LSB   = 10; // first bit of the 1024-byte block number
    localparam int BLOCK_W     = 12; // block number width

    // internally timed write and erase durations
    localparam int SYS_CLK_MHZ   = 250;
    localparam int PROG_TIME_NS  = 2000; // plain default, no figure given
    localparam int ERASE_TIME_NS = 4000; // plain default, no figure given
    localparam int PROG_CYCLES   = (PROG_TIME_NS * SYS_CLK_MHZ) / 1000;
    localparam int ERASE_CYCLES  = (ERASE_TIME_NS * SYS_CLK_MHZ) / 1000;

    // reset value of the control register
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // unlock progress
    typedef enum logic [1:0] {
        FSW_LK_IDLE  = 2'b00,
        FSW_LK_GOT55 = 2'b01,
        FSW_LK_ARMED = 2'b11
    } fsw_lock_t;

    // timed cycle state
    typedef enum logic [1:0] {
        FSW_ST_IDLE = 2'b00,
        FSW_ST_RUN  = 2'b01,
        FSW_ST_DONE = 2'b11
    } fsw_state_t;

    // control fields travelling together
    typedef struct packed {
        logic erase;
        logic write_error_flag;
        logic flash_write_enable;
        logic wr;
    } fsw_ctrl_t;

endpackage

// ==== verilog/fsw_top.sv ====
`timescale 1ns/1ps
module fsw_top #(
    parameter int PROG_CYC  = fsw_pkg::PROG_CYCLES,  // timed program length
    parameter int ERASE_CYC = fsw_pkg::ERASE_CYCLES  // timed erase length
) (
    // clock and resets
    input  wire logic        i_sys_clk,
    input  wire logic        i_rstn,       // master clear or watchdog reset
    input  wire logic        i_por_n,      // power-on reset only
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // flash array side
    input  wire logic [5:0]  i_hold_idx,   // array engine reads holding bytes
    output logic      [7:0]  o_hold_byte,
    output logic      [11:0] o_flash_block,
    output logic             o_flash_prog,
    output logic             o_flash_erase,
    // cpu side
    output logic             o_cpu_stall,
    output logic             o_irq
);

    // elaboration check on timer lengths
    if (PROG_CYC < 1 || ERASE_CYC < 1 || PROG_CYC > 65535 || ERASE_CYC > 65535) begin : g_chk
        $error("timer lengths out of range");
    end

    // reset synchronisers, both released through two flops
    logic [1:0] rst_sync_q;
    logic [1:0] por_sync_q;
    logic       rst_n;
    logic       por_n;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            por_sync_q <= 2'h0;
        end else begin
            por_sync_q <= {por_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];
    assign por_n = por_sync_q[1];

    // state
    fsw_pkg::fsw_ctrl_t                ctrl_q;       // control register fields
    fsw_pkg::fsw_lock_t                lock_q;       // unlock progress
    fsw_pkg::fsw_state_t               state_q;      // timed cycle state
    logic [fsw_pkg::PTR_W-1:0]         ptr_q;        // table_pointer
    logic [7:0]                        latch_q;      // table_latch
    logic [7:0]                        hold_q [fsw_pkg::HOLD_DEPTH]; // holding bytes
    logic [15:0]                       timer_q;      // cycle countdown
    logic                              op_erase_q;   // current cycle is erase
    logic [fsw_pkg::BLOCK_W-1:0]       block_q;      // block latched at start
    logic [fsw_pkg::IRQ_W-1:0]         irq_stat_q;
    logic [fsw_pkg::IRQ_W-1:0]         irq_mask_q;
    logic                              inflight_q;   // survives system reset
    logic                              write_error_flag_q;      // survives system reset
    logic                              err_evt_q;    // one-shot abort event
    logic [7:0]                        hold_rd_q;
    logic [31:0]                       prdata_q;

    // apb decode
    logic        acc;
    logic        wr_acc;
    logic        rd_acc;
    logic        hit_ctrl;
    logic        hit_key;
    logic        hit_ptr;
    logic        hit_lat;
    logic        hit_tblwr;
    logic        hit_stat;
    logic        hit_mask;
    logic        hit_status;
    logic        mapped;
    logic        start_req;
    logic        timer_end;
    logic [fsw_pkg::PTR_W-1:0] ptr_inc;
    logic [5:0]  hold_sel;
    logic [fsw_pkg::IRQ_W-1:0] irq_evt;
    logic [31:0] rd_mux;

    assign acc        = i_psel && i_penable;
    assign wr_acc     = acc && i_pwrite;
    assign rd_acc     = acc && !i_pwrite;
    assign hit_ctrl   = (i_paddr == fsw_pkg::ADDR_CTRL);
    assign hit_key    = (i_paddr == fsw_pkg::ADDR_KEY);
    assign hit_ptr    = (i_paddr == fsw_pkg::ADDR_TABLE_POINTER);
    assign hit_lat    = (i_paddr == fsw_pkg::ADDR_TBLLAT);
    assign hit_tblwr  = (i_paddr == fsw_pkg::ADDR_TBLWR);
    assign hit_stat   = (i_paddr == fsw_pkg::ADDR_IRQ_STAT);
    assign hit_mask   = (i_paddr == fsw_pkg::ADDR_IRQ_MASK);
    assign hit_status = (i_paddr == fsw_pkg::ADDR_STATUS);
    assign mapped     = hit_ctrl | hit_key | hit_ptr | hit_lat | hit_tblwr
                      | hit_stat | hit_mask | hit_status;

    // always ready; unmapped addresses answer with an error
    assign o_pready  = 1'b1;
    assign o_pslverr = acc && !mapped;

    // pointer increments before the store, so software presets it one low
    assign ptr_inc  = ptr_q + 22'h000001;
    // low index bits pick the holding byte; bit 6 wraps onto the 64 entries
    assign hold_sel = ptr_inc[5:0];

    // start only when armed, enabled, idle, and write-start written as one
    assign start_req = wr_acc && hit_ctrl && i_pwdata[fsw_pkg::CTRL_WR_BIT]
                     && ctrl_q.flash_write_enable && (lock_q == fsw_pkg::FSW_LK_ARMED)
                     && (state_q == fsw_pkg::FSW_ST_IDLE);
    assign timer_end = (state_q == fsw_pkg::FSW_ST_RUN) && (timer_q == 16'h0000);

    // event sources for the sticky status
    assign irq_evt = {err_evt_q, (state_q == fsw_pkg::FSW_ST_DONE)};

    // control and pointer registers
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q  <= fsw_pkg::CTRL_RESET[3:0];
            ptr_q   <= 22'h000000;
            latch_q <= 8'h00;
        end else begin
            if (wr_acc && hit_ctrl) begin
                ctrl_q.flash_write_enable  <= i_pwdata[fsw_pkg::CTRL_FLASH_WRITE_ENABLE_BIT];
                ctrl_q.erase <= i_pwdata[fsw_pkg::CTRL_ERASE_BIT];
            end
            // write start held through the cycle, only the timer or a system reset drops it
            if (start_req) begin
                ctrl_q.wr <= 1'b1;
            end else if (timer_end) begin
                ctrl_q.wr <= 1'b0;
            end
            ctrl_q.write_error_flag <= 1'b0; // live copy lives in write_error_flag_q
            if (wr_acc && hit_ptr) begin
                ptr_q <= i_pwdata[fsw_pkg::PTR_W-1:0];
            end else if (wr_acc && hit_tblwr) begin
                ptr_q <= ptr_inc;
            end
            if (wr_acc && hit_lat) begin
                latch_q <= i_pwdata[7:0];
            end
        end
    end

    // holding registers: short writes only, never cleared by a cycle
    always_ff @(posedge i_sys_clk) begin
        if (wr_acc && hit_tblwr) begin
            hold_q[hold_sel] <= latch_q;
        end
        hold_rd_q <= hold_q[i_hold_idx];
    end

    // unlock sequence tracker
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= fsw_pkg::FSW_LK_IDLE;
        end else if (wr_acc && hit_key) begin
            case (lock_q)
                fsw_pkg::FSW_LK_IDLE: begin
                    lock_q <= (i_pwdata[7:0] == fsw_pkg::KEY_FIRST)
                            ? fsw_pkg::FSW_LK_GOT55 : fsw_pkg::FSW_LK_IDLE;
                end
                fsw_pkg::FSW_LK_GOT55: begin
                    // a wrong second key drops back, order matters
                    lock_q <= (i_pwdata[7:0] == fsw_pkg::KEY_SECOND)
                            ? fsw_pkg::FSW_LK_ARMED : fsw_pkg::FSW_LK_IDLE;
                end
                default: begin
                    // any further key write after arming breaks the order
                    lock_q <= fsw_pkg::FSW_LK_IDLE;
                end
            endcase
        end else if (wr_acc && hit_ctrl) begin
            // arming is consumed by the next control write, used or not
            lock_q <= fsw_pkg::FSW_LK_IDLE;
        end
    end

    // timed cycle engine
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= fsw_pkg::FSW_ST_IDLE;
            timer_q    <= 16'h0000;
            op_erase_q <= 1'b0;
            block_q    <= 12'h000;
        end else begin
            case (state_q)
                fsw_pkg::FSW_ST_IDLE: begin
                    if (start_req) begin
                        state_q    <= fsw_pkg::FSW_ST_RUN;
                        op_erase_q <= ctrl_q.erase;
                        block_q    <= ptr_q[fsw_pkg::PTR_W-1:fsw_pkg::BLOCK_LSB];
                        timer_q    <= ctrl_q.erase ? 16'(ERASE_CYC - 1)
                                                   : 16'(PROG_CYC - 1);
                    end
                end
                fsw_pkg::FSW_ST_RUN: begin
                    if (timer_end) begin
                        state_q <= fsw_pkg::FSW_ST_DONE;
                    end else begin
                        timer_q <= timer_q - 16'h0001;
                    end
                end
                default: begin
                    state_q <= fsw_pkg::FSW_ST_IDLE;
                end
            endcase
        end
    end

    // abort detection: system reset leaves these alone, only power-on resets them, so a system reset that
    // lands mid-cycle leaves inflight set and turns into a write error
    always_ff @(posedge i_sys_clk or negedge por_n) begin
        if (!por_n) begin
            inflight_q <= 1'b0;
            write_error_flag_q    <= 1'b0;
            err_evt_q  <= 1'b0;
        end else begin
            err_evt_q <= 1'b0;
            if (!rst_n) begin
                inflight_q <= inflight_q;
            end else if (inflight_q && state_q == fsw_pkg::FSW_ST_IDLE) begin
                // back out of reset with a cycle marked in flight
                inflight_q <= 1'b0;
                write_error_flag_q    <= 1'b1;
                err_evt_q  <= 1'b1;
            end else if (start_req) begin
                inflight_q <= 1'b1;
            end else if (timer_end) begin
                inflight_q <= 1'b0;
            end
            // software may clear the flag; a new abort in that cycle wins
            if (wr_acc && hit_ctrl && !i_pwdata[fsw_pkg::CTRL_WRITE_ERROR_FLAG_BIT]
                && !(rst_n && inflight_q && state_q == fsw_pkg::FSW_ST_IDLE)) begin
                write_error_flag_q <= 1'b0;
            end
        end
    end

    // sticky interrupt status, cleared by a read; a new event wins
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= 2'h0;
            irq_mask_q <= 2'h0;
        end else begin
            irq_stat_q <= ((rd_acc && hit_stat) ? 2'h0 : irq_stat_q) | irq_evt;
            if (wr_acc && hit_mask) begin
                irq_mask_q <= i_pwdata[fsw_pkg::IRQ_W-1:0];
            end
        end
    end

    // read data selection
    assign rd_mux = hit_ctrl   ? {27'h0, ctrl_q.erase, write_error_flag_q, ctrl_q.flash_write_enable, ctrl_q.wr, 1'b0}
                  : hit_ptr    ? {10'h000, ptr_q}
                  : hit_lat    ? {24'h000000, latch_q}
                  : hit_stat   ? {30'h00000000, irq_stat_q}
                  : hit_mask   ? {30'h00000000, irq_mask_q}
                  : hit_status ? {28'h0000000, lock_q, state_q}
                  : 32'h00000000;

    // read data registered on the setup cycle so it is steady at access
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h00000000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    // outputs
    assign o_prdata      = prdata_q;
    assign o_hold_byte   = hold_rd_q;
    assign o_flash_block = block_q;
    assign o_flash_prog  = (state_q == fsw_pkg::FSW_ST_RUN) && !op_erase_q;
    assign o_flash_erase = (state_q == fsw_pkg::FSW_ST_RUN) && op_erase_q;
    assign o_cpu_stall   = (state_q == fsw_pkg::FSW_ST_RUN);
    assign o_irq         = |(irq_stat_q & irq_mask_q);

endmodule
